// [design/pivm_pkg.sv]
// package: constants and types of the peripheral interrupt vector map
//
// Contract
// [RULE1] sequence-abort request uses base+0x188, abort enable and mask, wakes from wait only.
// [RULE2] port over-current request uses base+0x108, enabled per odd pin, wait wake only.
// [RULE3] second timer channel 0 uses base+0x0ac, own enable and mask, wait wake only.
// [RULE4] second timer channel 1 uses base+0x0a8, own enable, wakes from wait only.
// [RULE5] supply monitor uses base+0x140, high and low enables, masked, wait wake only.
// [RULE6] serial ports use 0x19c and 0x198; seven enables; only receive edge wakes stop.
// [RULE7] vectors are 15-bit offsets added to base; reserved offsets carry no source.
// [RULE8] simultaneous pending requests are served with the higher offset taking precedence.
// [RULE9] a software-written base register relocates the whole table, base plus offset.
// [RULE10] never present a reserved offset; request only when enabled and unmasked.
package pivm_pkg;

    // ------------------------------------------------------------------
    // bus and vector widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int VEC_W  = 24;
    localparam int OFS_W  = 15;
    localparam int SRC_N  = 7;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_VBASE  = 8'h00;
    localparam logic [ADDR_W-1:0] REG_ENABLE = 8'h04;
    localparam logic [ADDR_W-1:0] REG_SCI0EN = 8'h08;
    localparam logic [ADDR_W-1:0] REG_SCI1EN = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;

    // ------------------------------------------------------------------
    // reset values and base write mask
    // ------------------------------------------------------------------
    localparam logic [VEC_W-1:0]  VBASE_RST  = 24'h00_0000;
    localparam logic [VEC_W-1:0]  VBASE_MASK = 24'hff_fffc;
    localparam logic [8:0]        ENABLE_RST = 9'h000;
    localparam logic [6:0]        SCIEN_RST  = 7'h00;

    // ------------------------------------------------------------------
    // enable register field positions
    // ------------------------------------------------------------------
    localparam int EN_SEQ_ABORT = 0;
    localparam int EN_OC_LSB    = 1;
    localparam int EN_OC_MSB    = 4;
    localparam int EN_CHAN0     = 5;
    localparam int EN_CHAN1     = 6;
    localparam int EN_SUP_HIGH  = 7;
    localparam int EN_SUP_LOW   = 8;

    // serial port enable/flag bit positions
    localparam int SCI_TX_EMPTY = 0;
    localparam int SCI_TX_DONE  = 1;
    localparam int SCI_RX_FULL  = 2;
    localparam int SCI_IDLE     = 3;
    localparam int SCI_RX_EDGE  = 4;
    localparam int SCI_BIT_ERR  = 5;
    localparam int SCI_BREAK    = 6;

    // status register field positions
    localparam int ST_PEND_LSB = 0;
    localparam int ST_REQ      = 8;
    localparam int ST_OFS_LSB  = 16;

    // ------------------------------------------------------------------
    // sources in priority order, index 0 highest; offsets from base
    // ------------------------------------------------------------------
    localparam int SRC_SCI0      = 0;
    localparam int SRC_SCI1      = 1;
    localparam int SRC_SEQ_ABORT = 2;
    localparam int SRC_SUPPLY    = 3;
    localparam int SRC_OVERCUR   = 4;
    localparam int SRC_CHAN0     = 5;
    localparam int SRC_CHAN1     = 6;

    localparam logic [OFS_W-1:0] OFS_SCI0      = 15'h019c;
    localparam logic [OFS_W-1:0] OFS_SCI1      = 15'h0198;
    localparam logic [OFS_W-1:0] OFS_SEQ_ABORT = 15'h0188;
    localparam logic [OFS_W-1:0] OFS_SUPPLY    = 15'h0140;
    localparam logic [OFS_W-1:0] OFS_OVERCUR   = 15'h0108;
    localparam logic [OFS_W-1:0] OFS_CHAN0     = 15'h00ac;
    localparam logic [OFS_W-1:0] OFS_CHAN1     = 15'h00a8;

    // ------------------------------------------------------------------
    // request lines from the peripherals
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       seq_abort;
        logic [3:0] overcurrent;
        logic       tim1_chan0;
        logic       tim1_chan1;
        logic       supply_high;
        logic       supply_low;
        logic [6:0] sci0;
        logic [6:0] sci1;
    } pivm_src_type;

    // answer to the core
    typedef struct packed {
        logic             req;
        logic [VEC_W-1:0] vector;
        logic             wake_wait;
        logic             wake_stop;
    } pivm_core_type;

endpackage

// [design/pivm_qual.sv]
// module: qualifies one request line by its local enables and the core mask
`timescale 1ns/100ps
module pivm_qual #(
    parameter int W = 1
) (
    input  wire logic [W-1:0] i_flags,
    input  wire logic [W-1:0] i_enables,
    input  wire logic         i_core_mask,
    output logic              o_req
);

    // any enabled flag, blocked while the core mask is set
    assign o_req = (|(i_flags & i_enables)) & ~i_core_mask; // [RULE10]

endmodule

// [design/pivm_top.sv]
// module: peripheral interrupt vector map with avalon-mm register slave
//
// Local design decisions: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
module pivm_top (
    input  wire logic                        i_clk,
    input  wire logic                        i_nrst,
    // avalon-mm slave
    input  wire logic [pivm_pkg::ADDR_W-1:0] i_avs_address,
    input  wire logic                        i_avs_read,
    input  wire logic                        i_avs_write,
    input  wire logic [pivm_pkg::DATA_W-1:0] i_avs_writedata,
    input  wire logic [3:0]                  i_avs_byteenable,
    output logic      [pivm_pkg::DATA_W-1:0] o_avs_readdata,
    output logic                             o_avs_waitrequest,
    // peripheral request lines and core state
    input  wire pivm_pkg::pivm_src_type      i_src,
    input  wire logic                        i_core_irq_mask,
    input  wire logic                        i_wait_mode,
    input  wire logic                        i_stop_mode,
    // answer to the core
    output pivm_pkg::pivm_core_type          o_core
);

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [pivm_pkg::VEC_W-1:0]  vector_base_reg_ff;
    logic [pivm_pkg::VEC_W-1:0]  nxt_vector_base_reg;
    logic [8:0]                  enable_ff;
    logic [8:0]                  nxt_enable;
    logic [6:0]                  sci0_en_ff;
    logic [6:0]                  nxt_sci0_en;
    logic [6:0]                  sci1_en_ff;
    logic [6:0]                  nxt_sci1_en;

    logic                        wait_ff;
    logic                        nxt_wait;
    logic [pivm_pkg::DATA_W-1:0] rdata_ff;
    logic [pivm_pkg::DATA_W-1:0] nxt_rdata;

    // core side state
    pivm_pkg::pivm_core_type     core_ff;
    pivm_pkg::pivm_core_type     nxt_core;
    logic [pivm_pkg::OFS_W-1:0]  ofs_ff;
    logic [pivm_pkg::OFS_W-1:0]  nxt_ofs;

    // ------------------------------------------------------------------
    // named enable fields
    // ------------------------------------------------------------------
    logic                        seq_abort_irq_en;
    logic [3:0]                  port_overcurrent_irq_en;
    logic                        chan0_irq_en;
    logic                        chan1_irq_en;
    logic                        supply_high_irq_en;
    logic                        supply_low_irq_en;

    assign seq_abort_irq_en        = enable_ff[pivm_pkg::EN_SEQ_ABORT];
    assign port_overcurrent_irq_en = enable_ff[pivm_pkg::EN_OC_MSB:pivm_pkg::EN_OC_LSB];
    assign chan0_irq_en            = enable_ff[pivm_pkg::EN_CHAN0];
    assign chan1_irq_en            = enable_ff[pivm_pkg::EN_CHAN1];
    assign supply_high_irq_en      = enable_ff[pivm_pkg::EN_SUP_HIGH];
    assign supply_low_irq_en       = enable_ff[pivm_pkg::EN_SUP_LOW];

    // ------------------------------------------------------------------
    // source qualification
    // ------------------------------------------------------------------
    // one pend bit per priority slot, index 0 highest
    logic [pivm_pkg::SRC_N-1:0]  pend;
    logic                        stop_wake;

    pivm_qual #(.W(1)) u_qual_seq (
        .i_flags     (i_src.seq_abort),
        .i_enables   (seq_abort_irq_en),
        .i_core_mask (i_core_irq_mask),
        .o_req       (pend[pivm_pkg::SRC_SEQ_ABORT])
    ); // [RULE1]

    // over-current enables sit on pins 7, 5, 3, 1 (msb first)
    pivm_qual #(.W(4)) u_qual_oc (
        .i_flags     (i_src.overcurrent),
        .i_enables   (port_overcurrent_irq_en),
        .i_core_mask (i_core_irq_mask),
        .o_req       (pend[pivm_pkg::SRC_OVERCUR])
    ); // [RULE2]

    pivm_qual #(.W(1)) u_qual_ch0 (
        .i_flags     (i_src.tim1_chan0),
        .i_enables   (chan0_irq_en),
        .i_core_mask (i_core_irq_mask),
        .o_req       (pend[pivm_pkg::SRC_CHAN0])
    ); // [RULE3]

    pivm_qual #(.W(1)) u_qual_ch1 (
        .i_flags     (i_src.tim1_chan1),
        .i_enables   (chan1_irq_en),
        .i_core_mask (i_core_irq_mask),
        .o_req       (pend[pivm_pkg::SRC_CHAN1])
    ); // [RULE4]

    pivm_qual #(.W(2)) u_qual_sup (
        .i_flags     ({i_src.supply_high, i_src.supply_low}),
        .i_enables   ({supply_high_irq_en, supply_low_irq_en}),
        .i_core_mask (i_core_irq_mask),
        .o_req       (pend[pivm_pkg::SRC_SUPPLY])
    ); // [RULE5]

    pivm_qual #(.W(7)) u_qual_sci0 (
        .i_flags     (i_src.sci0),
        .i_enables   (sci0_en_ff),
        .i_core_mask (i_core_irq_mask),
        .o_req       (pend[pivm_pkg::SRC_SCI0])
    ); // [RULE6]

    pivm_qual #(.W(7)) u_qual_sci1 (
        .i_flags     (i_src.sci1),
        .i_enables   (sci1_en_ff),
        .i_core_mask (i_core_irq_mask),
        .o_req       (pend[pivm_pkg::SRC_SCI1])
    ); // [RULE6]

    // only an enabled receive edge of either serial port wakes from stop
    pivm_qual #(.W(2)) u_qual_stop (
        .i_flags     ({i_src.sci0[pivm_pkg::SCI_RX_EDGE], i_src.sci1[pivm_pkg::SCI_RX_EDGE]}),
        .i_enables   ({sci0_en_ff[pivm_pkg::SCI_RX_EDGE], sci1_en_ff[pivm_pkg::SCI_RX_EDGE]}),
        .i_core_mask (i_core_irq_mask),
        .o_req       (stop_wake)
    ); // [RULE6]

    // ------------------------------------------------------------------
    // priority select and vector formation
    // ------------------------------------------------------------------
    logic                        any_pend;
    logic [pivm_pkg::OFS_W-1:0]  sel_ofs;

    always_comb begin
        any_pend = 1'b1;
        sel_ofs  = ofs_ff;
        // higher offset wins; only listed offsets can ever be chosen
        if (pend[pivm_pkg::SRC_SCI0]) begin // [RULE8]
            sel_ofs = pivm_pkg::OFS_SCI0; // [RULE6]
        end else if (pend[pivm_pkg::SRC_SCI1]) begin
            sel_ofs = pivm_pkg::OFS_SCI1; // [RULE6]
        end else if (pend[pivm_pkg::SRC_SEQ_ABORT]) begin
            sel_ofs = pivm_pkg::OFS_SEQ_ABORT; // [RULE1]
        end else if (pend[pivm_pkg::SRC_SUPPLY]) begin
            sel_ofs = pivm_pkg::OFS_SUPPLY; // [RULE5]
        end else if (pend[pivm_pkg::SRC_OVERCUR]) begin
            sel_ofs = pivm_pkg::OFS_OVERCUR; // [RULE2]
        end else if (pend[pivm_pkg::SRC_CHAN0]) begin
            sel_ofs = pivm_pkg::OFS_CHAN0; // [RULE3]
        end else if (pend[pivm_pkg::SRC_CHAN1]) begin
            sel_ofs = pivm_pkg::OFS_CHAN1; // [RULE4]
        end else begin
            // nothing pending: keep the last valid offset, never a reserved one
            any_pend = 1'b0; // [RULE10]
        end
    end

    always_comb begin
        nxt_ofs            = sel_ofs;
        nxt_core.req       = any_pend; // [RULE10]
        // base plus zero-extended 15-bit offset
        nxt_core.vector    = vector_base_reg_ff
                           + {{(pivm_pkg::VEC_W-pivm_pkg::OFS_W){1'b0}}, sel_ofs}; // [RULE7] [RULE9]

        // every listed source can leave wait; stop needs a receive edge
        nxt_core.wake_wait = i_wait_mode & any_pend;
        nxt_core.wake_stop = i_stop_mode & stop_wake; // [RULE6]
    end

    // ------------------------------------------------------------------
    // core answer register
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            core_ff.req       <= 1'b0;
            core_ff.vector    <= pivm_pkg::VBASE_RST;
            core_ff.wake_wait <= 1'b0;
            core_ff.wake_stop <= 1'b0;
            ofs_ff  <= pivm_pkg::OFS_SCI0;
        end else begin
            core_ff <= nxt_core;
            ofs_ff  <= nxt_ofs;
        end
    end

    assign o_core = core_ff;

    // ------------------------------------------------------------------
    // avalon-mm slave: one wait cycle, access completes when wait is low
    // ------------------------------------------------------------------
    logic                        bus_req;
    logic                        bus_done;
    logic [pivm_pkg::DATA_W-1:0] wmask;
    logic [pivm_pkg::DATA_W-1:0] status_word;

    assign bus_req  = i_avs_read | i_avs_write;
    // a write lands only on the edge where wait is low
    assign bus_done = bus_req & ~wait_ff;

    assign wmask    = {{8{i_avs_byteenable[3]}},
                       {8{i_avs_byteenable[2]}},
                       {8{i_avs_byteenable[1]}},
                       {8{i_avs_byteenable[0]}}};

    always_comb begin
        // unused bits read as zero
        status_word = '0;
        status_word[pivm_pkg::ST_PEND_LSB +: pivm_pkg::SRC_N] = pend;
        status_word[pivm_pkg::ST_REQ]                          = core_ff.req;
        status_word[pivm_pkg::ST_OFS_LSB +: pivm_pkg::OFS_W]   = ofs_ff;
    end

    // ------------------------------------------------------------------
    // register read and write decode
    // ------------------------------------------------------------------
    always_comb begin
        // wait drops for exactly one cycle per access
        nxt_wait            = ~(bus_req & wait_ff);
        nxt_rdata           = rdata_ff;
        nxt_vector_base_reg = vector_base_reg_ff;
        nxt_enable          = enable_ff;
        nxt_sci0_en         = sci0_en_ff;
        nxt_sci1_en         = sci1_en_ff;

        // read data prepared one cycle ahead so it stands while wait is low
        if (i_avs_read && wait_ff) begin
            case (i_avs_address)
                pivm_pkg::REG_VBASE: begin
                    nxt_rdata = {8'h00, vector_base_reg_ff};
                end
                pivm_pkg::REG_ENABLE: begin
                    nxt_rdata = {23'h00_0000, enable_ff};
                end
                pivm_pkg::REG_SCI0EN: begin
                    nxt_rdata = {25'h000_0000, sci0_en_ff};
                end
                pivm_pkg::REG_SCI1EN: begin
                    nxt_rdata = {25'h000_0000, sci1_en_ff};
                end
                pivm_pkg::REG_STATUS: begin
                    nxt_rdata = status_word;
                end
                default: begin
                    nxt_rdata = 32'h0000_0000;
                end
            endcase
        end

        if (i_avs_write && bus_done) begin
            case (i_avs_address)
                pivm_pkg::REG_VBASE: begin
                    nxt_vector_base_reg = ((vector_base_reg_ff & ~wmask[pivm_pkg::VEC_W-1:0])
                                        | (i_avs_writedata[pivm_pkg::VEC_W-1:0]
                                        & wmask[pivm_pkg::VEC_W-1:0]))
                                        & pivm_pkg::VBASE_MASK; // [RULE9]
                end
                pivm_pkg::REG_ENABLE: begin
                    nxt_enable = (enable_ff & ~wmask[8:0]) | (i_avs_writedata[8:0] & wmask[8:0]);
                end
                pivm_pkg::REG_SCI0EN: begin
                    if (i_avs_byteenable[0]) begin
                        nxt_sci0_en = i_avs_writedata[6:0];
                    end
                end
                pivm_pkg::REG_SCI1EN: begin
                    if (i_avs_byteenable[0]) begin
                        nxt_sci1_en = i_avs_writedata[6:0];
                    end
                end
                pivm_pkg::REG_STATUS: begin
                    // status is read-only: the write is dropped
                    nxt_enable = enable_ff;
                end
                default: begin
                    nxt_enable = enable_ff;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            wait_ff            <= 1'b1;
            rdata_ff           <= 32'h0000_0000;
            vector_base_reg_ff <= pivm_pkg::VBASE_RST;
            enable_ff          <= pivm_pkg::ENABLE_RST;
            sci0_en_ff         <= pivm_pkg::SCIEN_RST;
            sci1_en_ff         <= pivm_pkg::SCIEN_RST;
        end else begin
            wait_ff            <= nxt_wait;
            rdata_ff           <= nxt_rdata;
            vector_base_reg_ff <= nxt_vector_base_reg;
            enable_ff          <= nxt_enable;
            sci0_en_ff         <= nxt_sci0_en;
            sci1_en_ff         <= nxt_sci1_en;
        end
    end

    assign o_avs_readdata    = rdata_ff;
    assign o_avs_waitrequest = wait_ff;

endmodule

// [verif/pivm_top_asserts.sv]
// checker: port assertions of the interrupt vector map
`timescale 1ns/100ps
module pivm_top_asserts (
    input  wire logic                   i_clk,
    input  wire logic                   i_nrst,
    input  wire logic                   i_avs_read,
    input  wire logic                   i_avs_write,
    input  wire logic                   o_avs_waitrequest,
    input  wire pivm_pkg::pivm_src_type i_src,
    input  wire logic                   i_core_irq_mask,
    input  wire logic                   i_wait_mode,
    input  wire pivm_pkg::pivm_core_type o_core
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    // ------------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------------
    sequence s_bus_req;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence s_bus_done;
        !o_avs_waitrequest ##1 o_avs_waitrequest;
    endsequence
    AST_BUS_ANSWER: assert property (s_bus_req |=> s_bus_done)
        else $error("bus answer is not one low cycle after the request");
    AST_BUS_IDLE: assert property (!(i_avs_read || i_avs_write) |=> o_avs_waitrequest)
        else $error("waitrequest low without a request");

    // ------------------------------------------------------------------
    // core answer
    // ------------------------------------------------------------------
    AST_MASK_BLOCKS: assert property (i_core_irq_mask |=> !o_core.req && !o_core.wake_wait)
        else $error("request or wake raised while masked");
    AST_NO_SRC: assert property (i_src == '0 |=> !o_core.req)
        else $error("request raised with no source pending");
    AST_RISE_CAUSE: assert property ($rose(o_core.req) |-> $past(i_src) != '0)
        else $error("request rose without a pending source");
    AST_VEC_ALIGN: assert property (o_core.req |-> o_core.vector[1:0] == 2'h0)
        else $error("vector not word aligned");
    AST_STOP_EDGE_ONLY: assert property (!(i_src.sci0[4] || i_src.sci1[4]) |=> !o_core.wake_stop)
        else $error("stop wake without a receive edge flag");
    AST_WAIT_ONLY: assert property (!i_wait_mode |=> !o_core.wake_wait)
        else $error("wait wake outside wait mode");
    AST_WAKE_REQ: assert property (o_core.wake_wait |-> o_core.req)
        else $error("wait wake without a request");
    AST_VEC_HOLD: assert property ($fell(o_core.req) |-> $stable(o_core.vector))
        else $error("vector moved when request dropped");
endmodule

bind pivm_top pivm_top_asserts i_pivm_top_asserts (
    .i_clk             (i_clk),
    .i_nrst            (i_nrst),
    .i_avs_read        (i_avs_read),
    .i_avs_write       (i_avs_write),
    .o_avs_waitrequest (o_avs_waitrequest),
    .i_src             (i_src),
    .i_core_irq_mask   (i_core_irq_mask),
    .i_wait_mode       (i_wait_mode),
    .o_core            (o_core)
);

// [verif/pivm_core_model.sv]
// model: core that sets mask and low-power state and fetches vectors
`timescale 1ns/100ps
module pivm_core_model (
    input  wire logic                    i_clk,
    input  wire logic                    i_nrst,
    input  wire pivm_pkg::pivm_core_type i_core,
    input  wire logic                    i_mask_cmd,
    input  wire logic                    i_wait_cmd,
    input  wire logic                    i_stop_cmd,
    output logic                         o_core_irq_mask,
    output logic                         o_wait_mode,
    output logic                         o_stop_mode,
    output logic [pivm_pkg::VEC_W-1:0]   o_fetch_vec
);
    // core comes out of reset masked, like a real processor
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_core_irq_mask <= 1'b1;
            o_wait_mode     <= 1'b0;
            o_stop_mode     <= 1'b0;
            o_fetch_vec     <= 24'h00_0000;
        end else begin
            o_core_irq_mask <= i_mask_cmd;
            o_wait_mode     <= i_wait_cmd;
            o_stop_mode     <= i_stop_cmd;
            if (i_core.req && !o_core_irq_mask) begin
                o_fetch_vec <= i_core.vector;
            end
        end
    end
endmodule

// [verif/tb.sv]
// testbench: vector map register, priority, mask and wake checks
`timescale 1ns/100ps
module tb;
    logic                   i_clk, i_nrst, i_avs_read, i_avs_write, o_avs_waitrequest;
    logic [7:0]             i_avs_address;
    logic [31:0]            i_avs_writedata, o_avs_readdata, q;
    pivm_pkg::pivm_src_type i_src;
    pivm_pkg::pivm_core_type o_core;
    logic                   mask, wmode, smode, mask_cmd, wait_cmd, stop_cmd;
    logic [3:0]             be;
    logic [23:0]            fetch, base;
    int                     failures, compares, seed;

    pivm_top i_pivm_top (.i_clk(i_clk), .i_nrst(i_nrst), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(be), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .i_src(i_src), .i_core_irq_mask(mask),
        .i_wait_mode(wmode), .i_stop_mode(smode), .o_core(o_core));
    pivm_core_model i_pivm_core_model (.i_clk(i_clk), .i_nrst(i_nrst), .i_core(o_core),
        .i_mask_cmd(mask_cmd), .i_wait_cmd(wait_cmd), .i_stop_cmd(stop_cmd),
        .o_core_irq_mask(mask), .o_wait_mode(wmode), .o_stop_mode(smode), .o_fetch_vec(fetch));

    always #5 i_clk = ~i_clk;

    // ------------------------------------------------------------------
    // expectations and checks
    // ------------------------------------------------------------------
    function automatic logic [23:0] exp_vec(input pivm_pkg::pivm_src_type s, input logic [23:0] b);
        logic [14:0] o;
        o = 15'h0000;
        if (s.tim1_chan1) o = 15'h00a8;
        if (s.tim1_chan0) o = 15'h00ac;
        if (|s.overcurrent) o = 15'h0108;
        if (s.supply_high || s.supply_low) o = 15'h0140;
        if (s.seq_abort) o = 15'h0188;
        if (|s.sci1) o = 15'h0198;
        if (|s.sci0) o = 15'h019c;
        return b + {9'h000, o};
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic results;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        i_avs_address   <= a;
        i_avs_writedata <= d;
        i_avs_write     <= wr;
        i_avs_read      <= !wr;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 20);
        q = o_avs_readdata;
        if (n >= 20) begin
            failures++;
            $display("[FAIL] bus timeout expected 0 seen 1");
            results();
        end
        i_avs_read  <= 1'b0;
        i_avs_write <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic drive(input pivm_pkg::pivm_src_type s);
        i_src <= s;
        repeat (3) @(posedge i_clk);
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        i_clk = 0; i_nrst = 0; i_avs_read = 0; i_avs_write = 0; i_avs_address = 8'h00;
        i_avs_writedata = 32'h0; i_src = '0; mask_cmd = 1; wait_cmd = 0; stop_cmd = 0;
        failures = 0; compares = 0; seed = 32'hf589; be = 4'hf;
        repeat (8) @(posedge i_clk);
        i_nrst <= 1'b1;
        @(posedge i_clk);
        chk("core_rst", 32'h0, {5'h0, o_core});
        bus(0, 8'h00, 32'h0);
        chk("base_rst", 32'h0, q);
        bus(1, 8'h00, 32'h0012_3457);
        bus(0, 8'h00, 32'h0);
        chk("base", 32'h0012_3454, q);
        base = 24'h12_3454;
        bus(1, 8'h14, 32'hffff_ffff);
        bus(0, 8'h14, 32'h0);
        chk("unmapped", 32'h0, q);
        be <= 4'h2;
        bus(1, 8'h04, 32'hffff_ffff);
        be <= 4'hf;
        bus(0, 8'h04, 32'h0);
        chk("lanes", 32'h0000_0100, q);
        bus(1, 8'h04, 32'hffff_ffff);
        bus(1, 8'h08, 32'h0000_007f);
        bus(1, 8'h0c, 32'h0000_007f);
        bus(0, 8'h04, 32'h0);
        chk("enables", 32'h0000_01ff, q);
        mask_cmd <= 1'b0;
        $display("test registers done");
        for (int k = 0; k < 23; k++) begin
            drive(23'h1 << k);
            chk("single_req", 32'h1, o_core.req);
            chk("single_vec", exp_vec(23'h1 << k, base), o_core.vector);
        end
        chk("fetch", exp_vec(23'h40_0000, base), fetch);
        $display("test single sources done");
        for (int k = 0; k < 40; k++) begin
            drive(k < 2 ? 23'h7f_ffff >> (12 * k) : $random(seed));
            chk("rand_req", {31'h0, i_src != '0}, o_core.req);
            if (i_src != '0) chk("rand_vec", exp_vec(i_src, base), o_core.vector);
            bus(0, 8'h10, 32'h0);
            chk("status_req", {31'h0, i_src != '0}, q[8]);
        end
        $display("test priority done");
        mask_cmd <= 1'b1;
        drive(23'h40_0000);
        chk("masked", 32'h0, o_core.req);
        mask_cmd <= 1'b0;
        bus(1, 8'h04, 32'h0000_0002);
        drive(23'h20_0000);
        chk("pin7_off", 32'h0, o_core.req);
        drive(23'h04_0000);
        chk("pin1_on", {8'h0, base + 24'h108}, o_core.vector);
        bus(1, 8'h04, 32'h0000_0000);
        drive(23'h07_c000);
        chk("disabled", 32'h0, o_core.req);
        bus(1, 8'h04, 32'h0000_0100);
        drive(23'h00_8000);
        chk("sup_high_off", 32'h0, o_core.req);
        drive(23'h00_4000);
        chk("sup_low_on", exp_vec(23'h00_4000, base), o_core.vector);
        drive(23'h01_0000);
        chk("chan1_off", 32'h0, o_core.req);
        $display("test mask and enables done");
        bus(1, 8'h04, 32'h0000_01ff);
        wait_cmd <= 1'b1;
        stop_cmd <= 1'b1;
        drive(23'h40_0000);
        chk("wait_wake", 32'h1, o_core.wake_wait);
        chk("no_stop", 32'h0, o_core.wake_stop);
        wait_cmd <= 1'b0;
        drive(23'h00_0800);
        chk("edge_stop", 32'h1, o_core.wake_stop);
        drive(23'h00_0080);
        chk("tx_no_stop", 32'h0, o_core.wake_stop);
        stop_cmd <= 1'b0;
        bus(1, 8'h00, 32'h00ff_fffc);
        drive(23'h00_0100);
        chk("wrap_vec", 32'h0000_0198, o_core.vector);
        $display("test wake and relocation done");
        results();
    end
endmodule
